// >>> rtl/cic_top.sv
// Purpose: control and feature registers of one processor's cpu interface
// Assumes: accesses, end-of-interrupt and id queries are one-cycle pulses
// Notes:   answers come one clock after the request, from flops
`timescale 1ns/10ps
`default_nettype none
module cic_top
  import cic_pkg::*;
#(
  parameter bit             HAS_TOP        = 1'b1,  // top level exists
  parameter bit             TWO_SEC        = 1'b1,  // two security states
  parameter bit             A3_VALID       = 1'b0,  // nonzero affinity 3
  parameter bit             ERR_SUPPORT    = 1'b0,  // local error events
  parameter bit             ID_24BIT       = 1'b0,  // 24-bit identifiers
  parameter logic [2:0]     PRI_BITS_M1    = 3'h4,  // priority bits - 1
  parameter bit             NO_SEC_DISABLE = 1'b0,  // disable unsupported
  parameter cic_hint_mode_t HINT_MODE      = CIC_HINT_RW
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // system configuration levels
  input  wire logic        security_disabled,
  input  wire logic        sysreg_en_lower,
  input  wire logic        sysreg_en_top,
  // register access request
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_sel_top,
  input  wire logic        acc_at_top,
  input  wire logic        acc_secure,
  input  wire logic [31:0] acc_wdata,
  // register access answer
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             rsp_trap,
  output logic             rsp_undef,
  // end-of-interrupt and deactivate requests
  input  wire logic        eoi_valid,
  input  wire logic        dir_valid,
  input  wire logic        eoi_at_top,
  input  wire logic        eoi_secure,
  // end-of-interrupt effects
  output logic             prio_drop,
  output logic             deactivate,
  output logic             dir_ignored,
  // acknowledge / highest pending identifier query
  input  wire logic        idq_valid,
  input  wire logic        idq_group1,
  input  wire logic        idq_secure,
  input  wire logic        idq_at_top,
  input  wire logic        idq_wide_state,
  input  wire logic [23:0] idq_pending_id,
  output logic             idq_done,
  output logic [23:0]      idq_id,
  // control levels toward the rest of the interface
  output logic             priority_mask_hint_enable,
  output logic             bp_shared_secure,
  output logic             bp_shared_nonsecure,
  output logic [2:0]       group0_bp_min
);

  // raise a too-small width to the least the security model allows
  function automatic logic [2:0] pri_clamp(input logic [2:0] want,
                                           input logic       two_sec);
    logic [2:0] floor_m1;
    floor_m1 = (two_sec ? PRI_MIN_TWO_SEC : PRI_MIN_ONE_SEC) - 3'h1;
    pri_clamp = (want < floor_m1) ? floor_m1 : want;
  endfunction : pri_clamp

  // split mode that applies to a given level and security state
  function automatic logic split_for(input cic_state_t s,
                                     input logic       at_top,
                                     input logic       secure);
    if (at_top)
      split_for = s.split_top;
    else if (secure)
      split_for = s.split_s;
    else
      split_for = s.split_ns;
  endfunction : split_for

  // fixed feature values; one copy serves both registers
  localparam logic [2:0] PRI_CODE = pri_clamp(PRI_BITS_M1, TWO_SEC);
  localparam logic [2:0] ID_CODE  = ID_24BIT ? ID_CODE_24 : ID_CODE_16;

  cic_ctl_if ctl ();             // link to the field store
  cic_state_t st;                // current field values
  logic       sd_eff;            // security disable as honoured here
  logic       rt_eff;            // routing modifier as honoured here
  logic       reg_top;           // access addresses the top register
  logic       acc_undef;         // access not permitted at this level
  logic       acc_trap;          // access trapped by interface enable
  logic       acc_ok;            // access performs its read or write
  logic [31:0] rd_word;          // read value before the answer flop
  logic       eoi_split;         // split mode for the eoi context
  logic [23:0] id_sel;           // identifier before the answer flop

  assign st = ctl.state;

  // a device that cannot disable security acts as if it never is
  assign sd_eff = security_disabled && !NO_SEC_DISABLE;

  // without a top level the modifier has no effect
  assign rt_eff = HAS_TOP ? st.rt : 1'b0;

  assign reg_top = (cic_reg_t'(acc_sel_top) == CIC_REG_TOP);

  // permission: top register needs the top level and must exist;
  // enables are checked only after that
  always_comb
  begin
    acc_undef = 1'b0;
    acc_trap  = 1'b0;
    if (reg_top)
    begin
      if (!HAS_TOP || !acc_at_top)
        acc_undef = 1'b1;
      else if (!sysreg_en_top)
        acc_trap = 1'b1;
    end
    else if (acc_at_top ? !sysreg_en_top : !sysreg_en_lower)
    begin
      acc_trap = 1'b1;
    end
  end

  assign acc_ok = acc_valid && !acc_undef && !acc_trap;

  // read value; feature fields come from one shared source, so the
  // lower copy is the top copy whenever a top level exists
  always_comb
  begin
    rd_word = WORD_ZERO;
    rd_word[BIT_A3_VALID]    = A3_VALID;
    rd_word[BIT_ERR_SUPPORT] = ERR_SUPPORT;
    rd_word[ID_WIDTH_HI:ID_WIDTH_LO]   = ID_CODE;
    // same width whatever the security state or disable setting
    rd_word[PRI_WIDTH_HI:PRI_WIDTH_LO] = PRI_CODE;
    rd_word[BIT_HINT] = st.hint;
    if (reg_top)
    begin
      rd_word[BIT_NO_SEC_DIS]   = NO_SEC_DISABLE;
      rd_word[BIT_ROUTING_MOD]  = st.rt;
      rd_word[BIT_SPLIT_NS_LOW] = st.split_ns;
      rd_word[BIT_SPLIT_S_LOW]  = st.split_s;
      rd_word[BIT_SPLIT_TOP]    = st.split_top;
      rd_word[BIT_TOP_SHR_NS]   = st.shared_ns;
      rd_word[BIT_TOP_SHR_S]    = st.shared_s;
    end
    else
    begin
      // per-security copies seen through the lower register
      rd_word[BIT_LOW_SPLIT]  = acc_secure ? st.split_s
                                           : st.split_ns;
      rd_word[BIT_LOW_SHARED] = acc_secure ? st.shared_s
                                           : st.shared_ns;
    end
  end

  // write decode; read-only fields other than a constant hint enable never get a strobe
  always_comb
  begin
    ctl.wr_en  = '0;
    ctl.wr_val = '0;
    if (acc_ok && acc_write)
    begin
      ctl.wr_val.hint = acc_wdata[BIT_HINT];
      if (reg_top)
      begin
        ctl.wr_val.rt        = acc_wdata[BIT_ROUTING_MOD];
        ctl.wr_val.split_ns  = acc_wdata[BIT_SPLIT_NS_LOW];
        ctl.wr_val.split_s   = acc_wdata[BIT_SPLIT_S_LOW];
        ctl.wr_val.split_top = acc_wdata[BIT_SPLIT_TOP];
        ctl.wr_val.shared_ns = acc_wdata[BIT_TOP_SHR_NS];
        ctl.wr_val.shared_s  = acc_wdata[BIT_TOP_SHR_S];
        ctl.wr_en.hint       = 1'b1;
        ctl.wr_en.rt         = 1'b1;
        ctl.wr_en.split_ns   = 1'b1;
        ctl.wr_en.split_s    = 1'b1;
        ctl.wr_en.split_top  = 1'b1;
        ctl.wr_en.shared_ns  = 1'b1;
        ctl.wr_en.shared_s   = 1'b1;
      end
      else
      begin
        // lower write lands in the copy of the caller's state
        ctl.wr_val.split_ns  = acc_wdata[BIT_LOW_SPLIT];
        ctl.wr_val.split_s   = acc_wdata[BIT_LOW_SPLIT];
        ctl.wr_val.shared_ns = acc_wdata[BIT_LOW_SHARED];
        ctl.wr_val.shared_s  = acc_wdata[BIT_LOW_SHARED];
        ctl.wr_en.split_s    = acc_secure;
        ctl.wr_en.split_ns   = !acc_secure;
        // with a top level these are writable only when disabled
        ctl.wr_en.hint       = !HAS_TOP || sd_eff;
        ctl.wr_en.shared_s   = acc_secure &&
                               (!HAS_TOP || sd_eff);
        ctl.wr_en.shared_ns  = !acc_secure &&
                               (!HAS_TOP || sd_eff);
      end
    end
  end

  // field store; constant hint enable builds are handled inside
  cic_state_store #(
    .HINT_MODE (HINT_MODE)
  ) u_store (
    .clk_sys (clk_sys),
    .srst    (srst),
    .ctl     (ctl)
  );

  // access answer: one cycle after the request
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= WORD_ZERO;
      rsp_trap  <= 1'b0;
      rsp_undef <= 1'b0;
    end
    else
    begin
      rsp_valid <= acc_valid;
      rsp_trap  <= acc_valid && acc_trap;
      rsp_undef <= acc_valid && acc_undef;
      // refused or write accesses return zero data
      rsp_rdata <= (acc_ok && !acc_write) ? rd_word : WORD_ZERO;
    end
  end

  assign eoi_split = split_for(st, eoi_at_top, eoi_secure);

  // end of interrupt: drop always, deactivate only in combined mode;
  // a deactivate in combined mode is ignored rather than acted on
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prio_drop   <= 1'b0;
      deactivate  <= 1'b0;
      dir_ignored <= 1'b0;
    end
    else
    begin
      prio_drop   <= eoi_valid;
      deactivate  <= (eoi_valid && !eoi_split) ||
                     (dir_valid && eoi_split);
      dir_ignored <= dir_valid && !eoi_split;
    end
  end

  // special identifiers replace pending ones under the modifier
  always_comb
  begin
    id_sel = idq_pending_id;
    if (rt_eff && idq_at_top && idq_wide_state)
    begin
      if (!idq_group1 && idq_secure)
        id_sel = ID_SPECIAL_G0;
      else if (idq_group1 && !idq_secure)
        id_sel = ID_SPECIAL_G1;
    end
  end

  // identifier answer flop
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      idq_done <= 1'b0;
      idq_id   <= '0;
    end
    else
    begin
      idq_done <= idq_valid;
      if (idq_valid)
        idq_id <= id_sel;
    end
  end

  // level outputs toward the priority and preemption logic; software
  // must park the mask at all ones before clearing the hint
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      priority_mask_hint_enable <= 1'b0;
      bp_shared_secure          <= 1'b0;
      bp_shared_nonsecure       <= 1'b0;
      group0_bp_min             <= BP_TOP_CODE;
    end
    else
    begin
      priority_mask_hint_enable <= st.hint;
      bp_shared_secure          <= st.shared_s;
      bp_shared_nonsecure       <= st.shared_ns;
      // n implemented bits leave 7-n as the finest point
      group0_bp_min <= BP_TOP_CODE - PRI_CODE - 3'h1;
    end
  end

endmodule : cic_top
`default_nettype wire

// >>> shared/cic_pkg.sv
// Purpose: shared constants and types of the cpu interface control block
// Assumes: one 32-bit word per control register, system register access
// Notes:   bit positions, codes and reset values live here only
package cic_pkg;

  // field positions shared by both control registers
  localparam int unsigned BIT_A3_VALID     = 15;
  localparam int unsigned BIT_ERR_SUPPORT  = 14;
  localparam int unsigned ID_WIDTH_HI      = 13;
  localparam int unsigned ID_WIDTH_LO      = 11;
  localparam int unsigned PRI_WIDTH_HI     = 10;
  localparam int unsigned PRI_WIDTH_LO     = 8;
  localparam int unsigned BIT_HINT         = 6;
  // lower register only
  localparam int unsigned BIT_LOW_SPLIT    = 1;
  localparam int unsigned BIT_LOW_SHARED   = 0;
  // top register only
  localparam int unsigned BIT_NO_SEC_DIS   = 17;
  localparam int unsigned BIT_ROUTING_MOD  = 5;
  localparam int unsigned BIT_SPLIT_NS_LOW = 4;
  localparam int unsigned BIT_SPLIT_S_LOW  = 3;
  localparam int unsigned BIT_SPLIT_TOP    = 2;
  localparam int unsigned BIT_TOP_SHR_NS   = 1;
  localparam int unsigned BIT_TOP_SHR_S    = 0;

  // identifier width codes
  localparam logic [2:0] ID_CODE_16 = 3'h0;
  localparam logic [2:0] ID_CODE_24 = 3'h1;

  // least implemented priority bits per security model
  localparam logic [2:0] PRI_MIN_TWO_SEC = 3'h5;
  localparam logic [2:0] PRI_MIN_ONE_SEC = 3'h4;
  // largest binary point value; min group 0 point is this minus the width
  localparam logic [2:0] BP_TOP_CODE     = 3'h7;

  // special identifiers returned under the routing modifier
  localparam logic [23:0] ID_SPECIAL_G0 = 24'h0003FC;
  localparam logic [23:0] ID_SPECIAL_G1 = 24'h0003FD;

  // reset value of every writable control bit
  localparam logic RST_CTRL_BIT = 1'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // which control register an access addresses
  typedef enum logic [0:0] {
    CIC_REG_LOWER = 1'b0,
    CIC_REG_TOP   = 1'b1
  } cic_reg_t;

  // how the priority mask hint enable is built
  typedef enum logic [1:0] {
    CIC_HINT_RW  = 2'b00,
    CIC_HINT_RAZ = 2'b01,
    CIC_HINT_RAO = 2'b10
  } cic_hint_mode_t;

  // writable control state, one bit per field
  typedef struct packed {
    logic hint;
    logic rt;
    logic split_ns;
    logic split_s;
    logic split_top;
    logic shared_ns;
    logic shared_s;
  } cic_state_t;

endpackage : cic_pkg

// >>> shared/cic_ctl_if.sv
// Purpose: carries field writes from the decoder to the state store
// Assumes: wr_en and wr_val are one-cycle per field
// Notes:   state is the registered view after write-ignore masking
`timescale 1ns/10ps
`default_nettype none
interface cic_ctl_if;
  import cic_pkg::*;
  cic_state_t wr_en;   // per-field write strobe
  cic_state_t wr_val;  // per-field write value
  cic_state_t state;   // current field values
  modport ctrl  (output wr_en, output wr_val, input  state);
  modport store (input  wr_en, input  wr_val, output state);
endinterface : cic_ctl_if
`default_nettype wire

// >>> rtl/cic_state_store.sv
// Purpose: holds the writable control fields of both registers
// Assumes: strobes come from the access decoder, already permission-checked
// Notes:   the hint enable may be built as a constant instead of a flop
`timescale 1ns/10ps
`default_nettype none
module cic_state_store
  import cic_pkg::*;
#(
  parameter cic_hint_mode_t HINT_MODE = CIC_HINT_RW
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // field write side
  cic_ctl_if.store  ctl
);

  cic_state_t st_q;  // stored fields

  // all fields in one process, as the struct is a single variable;
  // the hint flop only takes writes in read/write builds
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q.hint      <= RST_CTRL_BIT;
      st_q.rt        <= RST_CTRL_BIT;
      st_q.split_ns  <= RST_CTRL_BIT;
      st_q.split_s   <= RST_CTRL_BIT;
      st_q.split_top <= RST_CTRL_BIT;
      st_q.shared_ns <= RST_CTRL_BIT;
      st_q.shared_s  <= RST_CTRL_BIT;
    end
    else
    begin
      if (ctl.wr_en.hint && HINT_MODE == CIC_HINT_RW)
        st_q.hint <= ctl.wr_val.hint;
      if (ctl.wr_en.rt)        st_q.rt        <= ctl.wr_val.rt;
      if (ctl.wr_en.split_ns)  st_q.split_ns  <= ctl.wr_val.split_ns;
      if (ctl.wr_en.split_s)   st_q.split_s   <= ctl.wr_val.split_s;
      if (ctl.wr_en.split_top) st_q.split_top <= ctl.wr_val.split_top;
      if (ctl.wr_en.shared_ns) st_q.shared_ns <= ctl.wr_val.shared_ns;
      if (ctl.wr_en.shared_s)  st_q.shared_s  <= ctl.wr_val.shared_s;
    end
  end

  // constant hint enable replaces the flop in read-only builds
  always_comb
  begin
    ctl.state = st_q;
    case (HINT_MODE)
      CIC_HINT_RAZ: ctl.state.hint = 1'b0;
      CIC_HINT_RAO: ctl.state.hint = 1'b1;
      default:      ctl.state.hint = st_q.hint;
    endcase
  end

endmodule : cic_state_store
`default_nettype wire

// >>> tb/cic_top_asserts.sv
// Purpose: port level checks of the cpu interface control block
// Assumes: access, eoi and id query each answered one clock later
// Notes:   bound into every cic_top instance, parameters handed on
`timescale 1ns/10ps
`default_nettype none
module cic_top_asserts
  import cic_pkg::*;
#(
  parameter bit         HAS_TOP        = 1'b1,
  parameter bit         TWO_SEC        = 1'b1,
  parameter bit         A3_VALID       = 1'b0,
  parameter bit         ERR_SUPPORT    = 1'b0,
  parameter bit         ID_24BIT       = 1'b0,
  parameter logic [2:0] PRI_BITS_M1    = 3'h4,
  parameter bit         NO_SEC_DISABLE = 1'b0
)(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // access request and answer
  input wire logic        security_disabled,
  input wire logic        sysreg_en_top,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic        acc_sel_top,
  input wire logic        acc_at_top,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic        rsp_trap,
  input wire logic        rsp_undef,
  // eoi, query and levels
  input wire logic        eoi_valid,
  input wire logic        dir_valid,
  input wire logic        prio_drop,
  input wire logic        deactivate,
  input wire logic        dir_ignored,
  input wire logic        idq_valid,
  input wire logic        idq_done,
  input wire logic [23:0] idq_id,
  input wire logic        priority_mask_hint_enable,
  input wire logic [2:0]  group0_bp_min
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // a width below the floor is raised, so expect the raised code
  localparam logic [2:0] FLOOR = TWO_SEC ? 3'h4 : 3'h3;
  localparam logic [2:0] PRI   = (PRI_BITS_M1 < FLOOR) ? FLOOR : PRI_BITS_M1;
  localparam logic [2:0] IDC   = ID_24BIT ? ID_CODE_24 : ID_CODE_16;
  logic rd_q;   // answer belongs to a read
  logic top_q;  // answer belongs to the top register
  // remember the kind of access whose answer comes next
  always_ff @(posedge clk_sys)
  begin
    rd_q  <= acc_valid && !acc_write;
    top_q <= acc_sel_top;
  end
  sequence s_good_read;
    rsp_valid && rd_q && !rsp_trap && !rsp_undef;
  endsequence
  sequence s_dir_req;
    dir_valid && !eoi_valid;
  endsequence
  sequence s_dir_done;
    deactivate != dir_ignored;
  endsequence
  a_undef_below_top: assert property (
    acc_valid && acc_sel_top && !acc_at_top |=>
    rsp_valid && rsp_undef && rsp_rdata == WORD_ZERO)
    else $error("top register answered below top level");
  a_trap_top_off: assert property (
    acc_valid && acc_sel_top && acc_at_top && !sysreg_en_top |=>
    rsp_trap && !rsp_undef && rsp_rdata == WORD_ZERO)
    else $error("disabled top access not trapped");
  a_id_width_ro: assert property (
    s_good_read |-> rsp_rdata[13:11] == IDC)
    else $error("identifier width code wrong");
  a_pri_width_ro: assert property (
    s_good_read |-> rsp_rdata[10:8] == PRI)
    else $error("priority width code wrong");
  a_feature_bits: assert property (
    s_good_read |-> rsp_rdata[15] == A3_VALID &&
    rsp_rdata[14] == ERR_SUPPORT && rsp_rdata[17] == (top_q & NO_SEC_DISABLE))
    else $error("feature bits wrong");
  a_bp_min_const: assert property (
    !$past(srst) |-> group0_bp_min == 3'h6 - PRI)
    else $error("group 0 point minimum wrong");
  a_eoi_drop: assert property (
    eoi_valid |=> prio_drop)
    else $error("end of interrupt gave no priority drop");
  a_dir_outcome: assert property (
    s_dir_req |=> s_dir_done)
    else $error("deactivate write neither done nor ignored");
  a_hint_locked: assert property (
    HAS_TOP && acc_valid && acc_write && !acc_sel_top &&
    !security_disabled |=> ##1 $stable(priority_mask_hint_enable))
    else $error("lower hint enable written while locked");
  a_idq_answer: assert property (
    idq_valid |=> idq_done)
    else $error("id query not answered next cycle");
  a_idq_hold: assert property (
    !idq_valid |=> !idq_done && $stable(idq_id))
    else $error("id result changed without a query");
endmodule : cic_top_asserts
bind cic_top cic_top_asserts #(.HAS_TOP(HAS_TOP), .TWO_SEC(TWO_SEC),
  .A3_VALID(A3_VALID), .ERR_SUPPORT(ERR_SUPPORT), .ID_24BIT(ID_24BIT),
  .PRI_BITS_M1(PRI_BITS_M1), .NO_SEC_DISABLE(NO_SEC_DISABLE))
  u_cic_top_asserts (.clk_sys, .srst, .security_disabled, .sysreg_en_top,
  .acc_valid, .acc_write, .acc_sel_top, .acc_at_top, .rsp_valid, .rsp_rdata,
  .rsp_trap, .rsp_undef, .eoi_valid, .dir_valid, .prio_drop, .deactivate,
  .dir_ignored, .idq_valid, .idq_done, .idq_id, .priority_mask_hint_enable,
  .group0_bp_min);
`default_nettype wire

// >>> tb/cic_core_model.sv
// Purpose: processor core issuing control register accesses
// Assumes: one access in flight, answer one clock after the request
// Notes:   released write data shows the inverse, never the last value
`timescale 1ns/10ps
`default_nettype none
module cic_core_model (
  // clock
  input  wire logic        clk_sys,
  // request side
  output logic             acc_valid,
  output logic             acc_write,
  output logic             acc_sel_top,
  output logic             acc_at_top,
  output logic             acc_secure,
  output logic [31:0]      acc_wdata,
  // answer side
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata,
  input  wire logic        rsp_trap,
  input  wire logic        rsp_undef
);
  // idle core: nothing requested
  initial
  begin
    acc_valid   = 1'b0;
    acc_write   = 1'b0;
    acc_sel_top = 1'b0;
    acc_at_top  = 1'b0;
    acc_secure  = 1'b0;
    acc_wdata   = 32'h0000_0000;
  end
  // software sets the mask to ones before clearing the hint
  // and keeps routing clear while the secure enable is set
  task automatic access(input logic wr, top, at_top, sec,
                        input logic [31:0] wd, output logic [34:0] ans);
    @(posedge clk_sys);
    acc_valid   <= 1'b1;
    acc_write   <= wr;
    acc_sel_top <= top;
    acc_at_top  <= at_top;
    acc_secure  <= sec;
    acc_wdata   <= wd;
    @(posedge clk_sys);
    acc_valid   <= 1'b0;
    acc_wdata   <= ~wd;
    #1;
    ans = {rsp_valid, rsp_trap, rsp_undef, rsp_rdata};
  endtask : access
endmodule : cic_core_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench of the cpu interface control block
// Assumes: two security states, nonzero affinity 3, 24-bit ids, 5 bits
// Notes:   every scenario reads its results back before it returns
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cic_pkg::*;
  // expected feature fields, identical in both registers
  localparam logic [31:0] FEAT = (32'h1 << BIT_A3_VALID) |
    ({29'h0, ID_CODE_24} << ID_WIDTH_LO) | (32'h4 << PRI_WIDTH_LO);
  localparam logic [2:0] OK = 3'h4;   // answered, no fault
  localparam logic [2:0] UND = 3'h5;  // answered undefined
  localparam logic [2:0] TRP = 3'h6;  // answered trapped
  logic        clk_sys, srst, security_disabled;
  logic        sysreg_en_lower, sysreg_en_top;
  logic        acc_valid, acc_write, acc_sel_top, acc_at_top, acc_secure;
  logic [31:0] acc_wdata, rsp_rdata;
  logic        rsp_valid, rsp_trap, rsp_undef;
  logic        eoi_valid, dir_valid, eoi_at_top, eoi_secure;
  logic        prio_drop, deactivate, dir_ignored;
  logic        idq_valid, idq_group1, idq_secure, idq_at_top;
  logic        idq_wide_state, idq_done, hint, bp_s, bp_ns;
  logic [23:0] idq_pending_id, idq_id;
  logic [2:0]  bp_min;
  int          bad_count, compares, cycles;
  cic_core_model u_cic_core_model (.clk_sys, .acc_valid, .acc_write,
    .acc_sel_top, .acc_at_top, .acc_secure, .acc_wdata, .rsp_valid,
    .rsp_rdata, .rsp_trap, .rsp_undef);
  cic_top #(.A3_VALID(1'b1), .ID_24BIT(1'b1)) u_cic_top (.clk_sys,
    .srst, .security_disabled, .sysreg_en_lower, .sysreg_en_top,
    .acc_valid, .acc_write, .acc_sel_top, .acc_at_top, .acc_secure,
    .acc_wdata, .rsp_valid, .rsp_rdata, .rsp_trap, .rsp_undef, .eoi_valid,
    .dir_valid, .eoi_at_top, .eoi_secure, .prio_drop, .deactivate,
    .dir_ignored, .idq_valid, .idq_group1, .idq_secure, .idq_at_top,
    .idq_wide_state, .idq_pending_id, .idq_done, .idq_id,
    .priority_mask_hint_enable(hint), .bp_shared_secure(bp_s),
    .bp_shared_nonsecure(bp_ns), .group0_bp_min(bp_min));
  // one comparison, counted
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // counts, verdict and end of run
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // one access through the core model, answer flags and data judged
  task automatic acc(input logic wr, top, at_top, sec,
                     input logic [31:0] wd, exp, input logic [2:0] fl);
    logic [34:0] ans;
    u_cic_core_model.access(wr, top, at_top, sec, wd, ans);
    chk("answer flags", {29'h0, ans[34:32]}, {29'h0, fl});
    chk("read data", ans[31:0], exp);
  endtask : acc
  // one eoi or deactivate pulse; result is drop, deactivate, ignored
  task automatic eoi(input logic e, d, input logic [2:0] exp);
    @(posedge clk_sys);
    eoi_valid <= e;
    dir_valid <= d;
    @(posedge clk_sys);
    eoi_valid <= 1'b0;
    dir_valid <= 1'b0;
    #1;
    chk("eoi effect", {29'h0, prio_drop, deactivate, dir_ignored},
        {29'h0, exp});
  endtask : eoi
  // one id query from 64-bit state
  task automatic idq(input logic g1, sec, top, input logic [23:0] exp);
    @(posedge clk_sys);
    idq_valid  <= 1'b1;
    idq_group1 <= g1;
    idq_secure <= sec;
    idq_at_top <= top;
    @(posedge clk_sys);
    idq_valid  <= 1'b0;
    #1;
    chk("query id", {7'h0, idq_done, idq_id}, {8'h01, exp});
  endtask : idq
  // reset contents and read-only fields of both registers
  task automatic t_reset_read();
    acc(1'b0, 1'b1, 1'b1, 1'b0, 32'h0, FEAT, OK);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 32'h0, FEAT, OK);
    chk("bp min", {29'h0, bp_min}, 32'h2);
    chk("hint", {31'h0, hint}, 32'h0);
  endtask : t_reset_read
  // all ones into the top register: only writable bits take it
  task automatic t_top_fields();
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'hFFFF_FFFF, 32'h0, OK);
    acc(1'b0, 1'b1, 1'b1, 1'b0, 32'h0, FEAT | 32'h7F, OK);
    chk("hint", {29'h0, hint, bp_s, bp_ns}, 32'h7);
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'h0A, 32'h0, OK);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 32'h0, FEAT | 32'h2, OK);
    acc(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, FEAT | 32'h1, OK);
    chk("shared", {30'h0, bp_s, bp_ns}, 32'h1);
  endtask : t_top_fields
  // lower hint and shared bits locked until security is disabled
  task automatic t_lower_lock();
    acc(1'b1, 1'b0, 1'b0, 1'b1, 32'h41, 32'h0, OK);
    acc(1'b0, 1'b1, 1'b1, 1'b0, 32'h0, FEAT | 32'h2, OK);
    @(posedge clk_sys);
    security_disabled <= 1'b1;
    acc(1'b1, 1'b0, 1'b0, 1'b0, 32'h43, 32'h0, OK);
    acc(1'b0, 1'b1, 1'b1, 1'b0, 32'h0, FEAT | 32'h52, OK);
    chk("hint", {31'h0, hint}, 32'h1);
    @(posedge clk_sys);
    security_disabled <= 1'b0;
  endtask : t_lower_lock
  // top register below top level, and with its enable off
  task automatic t_refuse();
    acc(1'b0, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0, UND);
    @(posedge clk_sys);
    sysreg_en_top <= 1'b0;
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0, TRP);
    @(posedge clk_sys);
    sysreg_en_top <= 1'b1;
    acc(1'b0, 1'b1, 1'b1, 1'b0, 32'h0, FEAT | 32'h52, OK);
  endtask : t_refuse
  // combined and split end of interrupt, per context
  task automatic t_eoi();
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0, OK);
    @(posedge clk_sys);
    eoi_at_top <= 1'b1;
    eoi(1'b1, 1'b0, 3'h6);
    eoi(1'b0, 1'b1, 3'h1);
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'h04, 32'h0, OK);
    eoi(1'b1, 1'b0, 3'h4);
    eoi(1'b0, 1'b1, 3'h2);
    @(posedge clk_sys);
    eoi_at_top <= 1'b0;
    eoi_secure <= 1'b1;
    eoi(1'b1, 1'b0, 3'h6);
  endtask : t_eoi
  // routing modifier replaces ids only at top level
  task automatic t_route();
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'h20, 32'h0, OK);
    idq(1'b0, 1'b1, 1'b1, ID_SPECIAL_G0);
    idq(1'b1, 1'b0, 1'b1, ID_SPECIAL_G1);
    idq(1'b0, 1'b1, 1'b0, 24'h000123);
    acc(1'b1, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0, OK);
    idq(1'b0, 1'b1, 1'b1, 24'h000123);
  endtask : t_route
  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // hang guard: the whole run needs under 70 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    srst = 1'b1;
    security_disabled = 1'b0;
    sysreg_en_lower = 1'b1;
    sysreg_en_top = 1'b1;
    {eoi_valid, dir_valid, eoi_at_top, eoi_secure} = 4'h0;
    {idq_valid, idq_group1, idq_secure, idq_at_top} = 4'h0;
    idq_wide_state = 1'b1;
    idq_pending_id = 24'h000123;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset_read();
    t_top_fields();
    t_lower_lock();
    t_refuse();
    t_eoi();
    t_route();
    stop_test();
  end
endmodule : tb
`default_nettype wire
